// ### include/otpsr_pkg.sv
/*
  Constants, opcodes and states shared by the security-region access block.
  Assumes a 125 MHz core clock and an SPI host in mode 0 or mode 3.
*/
`default_nettype none
package otpsr_pkg;
  localparam int unsigned CLK_MHZ      = 125;
  localparam int unsigned BITS         = 8;
  localparam int unsigned REGION_BYTES = 128;
  localparam int unsigned USER_BYTES   = 64;
  localparam int unsigned BUF_BYTES    = 256;
  localparam int unsigned USER_AW      = 6;
  localparam int unsigned REGION_AW    = 7;
  localparam int unsigned BUF_AW       = 8;
  localparam int unsigned ADDR_BYTES   = 3;
  localparam int unsigned DUMMY_BYTES  = 2;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_WEL_BIT  = 1;

  localparam logic [7:0] OP_PROG   = 8'h9B;
  localparam logic [7:0] OP_READ   = 8'h77;
  localparam logic [7:0] OP_STATUS = 8'h05;
  localparam logic [7:0] OP_WREN   = 8'h06;
  localparam logic [7:0] OP_WRDI   = 8'h04;
  localparam logic [7:0] ERASED    = 8'hFF;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [2:0] LAST_BIT  = 3'h7;

  // default time of one programming pass, in microseconds
  localparam int unsigned SECURITY_PROGRAM_TIME_US_DEF = 500;

  typedef enum logic [2:0] {
    OTPSR_OPC,
    OTPSR_ADDR,
    OTPSR_DUMMY,
    OTPSR_DATA,
    OTPSR_RDOUT,
    OTPSR_STOUT,
    OTPSR_SKIP
  } otpsr_state_e;
endpackage
`default_nettype wire

// ### hdl/otpsr_sync.sv
/*
  Two-flop synchroniser for a group of pin levels.
  Assumes the inputs are asynchronous to clk and only levels are passed.
*/
`timescale 1ns/10ps
`default_nettype none
module otpsr_sync #(
  parameter int unsigned W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // otpsr_sync
`default_nettype wire

// ### hdl/otpsr_array.sv
/*
  The 128-byte security region: 64 user bytes plus 64 fixed factory bytes,
  and the one-shot lock of the user half.
  Assumes writes come only from the programming pass of the command logic.
*/
`timescale 1ns/10ps
`default_nettype none
module otpsr_array
  import otpsr_pkg::*;
#(
  // arbitrary value, seeds the per-part factory bytes
  parameter logic [7:0] FACTORY_SEED = 8'h5A
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 wr_en,
  input  wire logic [USER_AW-1:0]   wr_idx,
  input  wire logic [7:0]           wr_data,
  input  wire logic                 lock_set,
  input  wire logic [REGION_AW-1:0] rd_addr,
  output logic      [7:0]           rd_data,
  output logic                      locked
);
  logic [7:0] user_r   [USER_BYTES];
  logic [7:0] user_nxt [USER_BYTES];
  logic       locked_nxt;

  function automatic logic [7:0] factory_byte(input logic [USER_AW-1:0] idx);
    factory_byte = FACTORY_SEED ^ {idx, 2'h0} ^ {2'h0, idx};
  endfunction

  always_comb begin
    user_nxt   = user_r;
    locked_nxt = locked | lock_set;
    if (wr_en) begin
      user_nxt[wr_idx] = wr_data;
    end
    // upper half is fixed; no path ever writes it
    if (rd_addr[REGION_AW-1]) begin // RULE_01
      rd_data = factory_byte(rd_addr[USER_AW-1:0]);
    end else begin
      rd_data = user_r[rd_addr[USER_AW-1:0]];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < USER_BYTES; i++) begin
        user_r[i] <= ERASED;
      end
      locked <= 1'b0;
    end else begin
      user_r <= user_nxt;
      locked <= locked_nxt;
    end
  end
endmodule // otpsr_array
`default_nettype wire

// ### hdl/otpsr_top.sv
/*
  Command logic for the one-time-programmable security region of a serial
  flash: program (9Bh), read (77h), status read (05h), write enable/disable.
  Assumes an SPI host in mode 0 or 3 with SCK well below clk/4; all pins are
  asynchronous and are synchronised before use.
*/
// What this block does
// [RULE_01] 128-byte region: bytes 0-63 user programmable, 64-127 fixed factory data.
// [RULE_02] user half is one unit; once programmed, any further program is refused.
// [RULE_03] programming needs no prior erase; user bytes start erased.
// [RULE_04] host sets the write-enable latch first, otherwise no program happens.
// [RULE_05] program frame: opcode 9Bh, three address bytes, then data into buffer.
// [RULE_06] program decodes only the low six address bits.
// [RULE_07] program data past byte 63 wraps to byte 0.
// [RULE_08] beyond 64 data bytes, only the last 64 are kept.
// [RULE_09] on release, buffered bytes are written; untouched user bytes stay FFh.
// [RULE_10] status shows busy during the self-timed programming pass.
// [RULE_11] abort if release comes before address plus one byte, or mid-byte.
// [RULE_12] every program abort clears the write-enable latch.
// [RULE_13] successful programming clears the write-enable latch before it ends.
// [RULE_14] program uses the shared 256-byte buffer, overwriting its old contents.
// [RULE_15] read frame: opcode 77h, three address bytes, two dummy bytes, then data.
// [RULE_16] read wraps from 7Fh to 00h with no gap.
// [RULE_17] chip-select release ends the read and floats the output.
// [RULE_18] status bit 0 is busy.
// [RULE_19] opcode 05h streams status bytes, refreshed while selected, each followed by a 00h byte.
// [RULE_20] status bit 1 is the write-enable latch.
`timescale 1ns/10ps
`default_nettype none
module otpsr_top #(
  parameter int unsigned SECURITY_PROGRAM_TIME_US = otpsr_pkg::SECURITY_PROGRAM_TIME_US_DEF
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic cs_n_pin,
  input  wire logic sck_pin,
  input  wire logic si_pin,
  output logic      so,
  output logic      so_oe
);
  import otpsr_pkg::*;

  localparam int unsigned PROG_CYCLES = SECURITY_PROGRAM_TIME_US * CLK_MHZ;
  localparam logic [31:0] PROG_LAST   = 32'(PROG_CYCLES - 1);
  localparam logic [31:0] USER_LAST   = 32'(USER_BYTES - 1);
  localparam logic [31:0] USER_CNT    = 32'(USER_BYTES);
  localparam logic [3:0]  ADDR_LAST   = 4'(ADDR_BYTES - 1);
  localparam logic [3:0]  DUMMY_LAST  = 4'(DUMMY_BYTES - 1);

  // synchronised pins and edge history
  logic cs_n_s;
  logic sck_s;
  logic si_s;
  logic cs_prev_r;
  logic sck_prev_r;

  otpsr_sync #(
    .W       (3),
    .RST_VAL (3'h4)
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({cs_n_pin, sck_pin, si_pin}),
    .q     ({cs_n_s, sck_s, si_s})
  );

  logic frame;
  logic cs_rel;
  logic sck_rise;
  logic sck_fall;
  assign frame    = ~cs_n_s;
  assign cs_rel   = cs_n_s & ~cs_prev_r;
  assign sck_rise = frame & sck_s & ~sck_prev_r;
  assign sck_fall = frame & ~sck_s & sck_prev_r;

  // command state
  otpsr_state_e         state_r, state_nxt;
  logic [2:0]           bit_r, bit_nxt;
  logic [7:0]           sh_r, sh_nxt;
  logic [3:0]           cnt_r, cnt_nxt;
  logic [REGION_AW-1:0] addr_r, addr_nxt;
  logic                 prog_cmd_r, prog_cmd_nxt;
  logic                 got_data_r, got_data_nxt;
  logic [2:0]           dbit_r, dbit_nxt;
  logic                 stat_sel_r, stat_sel_nxt;
  logic                 so_nxt;
  logic                 oe_nxt;
  // latch, busy and programming pass
  logic                 wel_r, wel_nxt;
  logic                 busy_r, busy_nxt;
  logic [31:0]          timer_r, timer_nxt;
  // shared page buffer and which user bytes it holds
  logic [7:0]           buf_r   [BUF_BYTES];
  logic [7:0]           buf_nxt [BUF_BYTES];
  logic [USER_BYTES-1:0] valid_r, valid_nxt;

  // array link
  logic                 locked;
  logic [7:0]           rd_data;
  logic                 wr_en;
  logic [USER_AW-1:0]   wr_idx;
  logic [7:0]           wr_data;
  logic                 lock_set;

  otpsr_array u_array (
    .clk      (clk),
    .rst_n    (rst_n),
    .wr_en    (wr_en),
    .wr_idx   (wr_idx),
    .wr_data  (wr_data),
    .lock_set (lock_set),
    .rd_addr  (addr_r),
    .rd_data  (rd_data),
    .locked   (locked)
  );

  logic [7:0] byte_in;
  logic [7:0] stat_byte;
  logic [7:0] out_byte;
  logic       prog_ok;

  always_comb begin
    byte_in = {sh_r[6:0], si_s};

    stat_byte = ZERO_BYTE;
    if (!stat_sel_r) begin
      stat_byte[STAT_BUSY_BIT] = busy_r; // RULE_18
      stat_byte[STAT_WEL_BIT]  = wel_r;  // RULE_20
    end
    out_byte = (state_r == OTPSR_RDOUT) ? rd_data : stat_byte;

    // one byte per cycle of the pass; unsent bytes are written as erased
    wr_idx   = timer_r[USER_AW-1:0];
    wr_en    = busy_r && (timer_r < USER_CNT);
    wr_data  = valid_r[wr_idx] ? buf_r[wr_idx] : ERASED; // RULE_09
    lock_set = busy_r && (timer_r == USER_LAST);         // RULE_02

    // address plus a whole data byte, released on a byte boundary
    prog_ok = got_data_r && (bit_r == 3'h0); // RULE_11
  end

  always_comb begin
    state_nxt    = state_r;
    bit_nxt      = bit_r;
    sh_nxt       = sh_r;
    cnt_nxt      = cnt_r;
    addr_nxt     = addr_r;
    prog_cmd_nxt = prog_cmd_r;
    got_data_nxt = got_data_r;
    dbit_nxt     = dbit_r;
    stat_sel_nxt = stat_sel_r;
    so_nxt       = so;
    oe_nxt       = so_oe;
    wel_nxt      = wel_r;
    busy_nxt     = busy_r;
    timer_nxt    = timer_r;
    buf_nxt      = buf_r;
    valid_nxt    = valid_r;

    if (busy_r) begin
      timer_nxt = timer_r + 32'h1;
      if (timer_r == PROG_LAST) begin
        busy_nxt  = 1'b0; // RULE_10
        timer_nxt = '0;
      end
    end

    if (cs_rel) begin
      state_nxt = OTPSR_OPC;
      bit_nxt   = 3'h0;
      oe_nxt    = 1'b0; // RULE_17
      if (prog_cmd_r && (state_r == OTPSR_ADDR || state_r == OTPSR_DATA)) begin
        // no erase step: the erased user half is programmed directly
        if (prog_ok && wel_r && !locked && !busy_r) begin // RULE_03 RULE_04
          busy_nxt  = 1'b1; // RULE_10
          timer_nxt = '0;
        end
        wel_nxt = 1'b0; // RULE_12 RULE_13
      end
      prog_cmd_nxt = 1'b0;
    end else if (sck_rise) begin
      sh_nxt  = byte_in;
      bit_nxt = bit_r + 3'h1;
      case (state_r)
        OTPSR_OPC: begin
          if (bit_r == LAST_BIT) begin
            cnt_nxt   = 4'h0;
            dbit_nxt  = 3'h0;
            state_nxt = OTPSR_SKIP;
            if (byte_in == OP_STATUS) begin
              state_nxt    = OTPSR_STOUT; // RULE_19
              stat_sel_nxt = 1'b0;
              oe_nxt       = 1'b1;
            end else if (!busy_r) begin
              if (byte_in == OP_PROG) begin
                state_nxt    = OTPSR_ADDR; // RULE_05
                prog_cmd_nxt = 1'b1;
                got_data_nxt = 1'b0;
                valid_nxt    = '0;
              end else if (byte_in == OP_READ) begin
                state_nxt = OTPSR_ADDR; // RULE_15
              end else if (byte_in == OP_WREN) begin
                wel_nxt = 1'b1;
              end else if (byte_in == OP_WRDI) begin
                wel_nxt = 1'b0;
              end
            end
          end
        end
        OTPSR_ADDR: begin
          if (bit_r == LAST_BIT) begin
            addr_nxt = byte_in[REGION_AW-1:0];
            cnt_nxt  = cnt_r + 4'h1;
            if (cnt_r == ADDR_LAST) begin
              cnt_nxt   = 4'h0;
              state_nxt = prog_cmd_r ? OTPSR_DATA : OTPSR_DUMMY;
            end
          end
        end
        OTPSR_DUMMY: begin
          if (bit_r == LAST_BIT) begin
            cnt_nxt = cnt_r + 4'h1;
            if (cnt_r == DUMMY_LAST) begin
              state_nxt = OTPSR_RDOUT; // RULE_15
              oe_nxt    = 1'b1;
            end
          end
        end
        OTPSR_DATA: begin
          if (bit_r == LAST_BIT) begin
            // later bytes overwrite earlier ones at the same slot
            buf_nxt[BUF_AW'(addr_r[USER_AW-1:0])] = byte_in; // RULE_05 RULE_08 RULE_14
            valid_nxt[addr_r[USER_AW-1:0]] = 1'b1;             // RULE_06
            addr_nxt = {1'b0, addr_r[USER_AW-1:0] + 6'h1};     // RULE_07
            got_data_nxt = 1'b1;
          end
        end
        OTPSR_RDOUT: begin
          dbit_nxt = dbit_r + 3'h1;
          if (dbit_r == LAST_BIT) begin
            addr_nxt = addr_r + 7'h1; // RULE_16
          end
        end
        OTPSR_STOUT: begin
          dbit_nxt = dbit_r + 3'h1;
          if (dbit_r == LAST_BIT) begin
            stat_sel_nxt = ~stat_sel_r; // RULE_19
          end
        end
        default: begin
          state_nxt = OTPSR_SKIP;
        end
      endcase
    end else if (sck_fall && so_oe) begin
      // output moves on falling edges, msb first
      so_nxt = out_byte[~dbit_r]; // RULE_15 RULE_19
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_prev_r  <= 1'b1;
      sck_prev_r <= 1'b0;
      state_r    <= OTPSR_OPC;
      bit_r      <= 3'h0;
      sh_r       <= ZERO_BYTE;
      cnt_r      <= 4'h0;
      addr_r     <= '0;
      prog_cmd_r <= 1'b0;
      got_data_r <= 1'b0;
      dbit_r     <= 3'h0;
      stat_sel_r <= 1'b0;
      so         <= 1'b0;
      so_oe      <= 1'b0;
      wel_r      <= 1'b0;
      busy_r     <= 1'b0;
      timer_r    <= '0;
      valid_r    <= '0;
      for (int i = 0; i < BUF_BYTES; i++) begin
        buf_r[i] <= ERASED;
      end
    end else begin
      cs_prev_r  <= cs_n_s;
      sck_prev_r <= sck_s;
      state_r    <= state_nxt;
      bit_r      <= bit_nxt;
      sh_r       <= sh_nxt;
      cnt_r      <= cnt_nxt;
      addr_r     <= addr_nxt;
      prog_cmd_r <= prog_cmd_nxt;
      got_data_r <= got_data_nxt;
      dbit_r     <= dbit_nxt;
      stat_sel_r <= stat_sel_nxt;
      so         <= so_nxt;
      so_oe      <= oe_nxt;
      wel_r      <= wel_nxt;
      busy_r     <= busy_nxt;
      timer_r    <= timer_nxt;
      valid_r    <= valid_nxt;
      buf_r      <= buf_nxt;
    end
  end
endmodule // otpsr_top
`default_nettype wire

// ### verif/otpsr_asserts.sv
/*
  Pin-level checks on otpsr_top: when the serial output may be enabled
  and when it may change.
  Assumes an SPI host in mode 0 with SCK phases of at least 5 clk.
*/
`timescale 1ns/10ps
`default_nettype none
module otpsr_asserts
  import otpsr_pkg::*;
#(
  parameter int unsigned SECURITY_PROGRAM_TIME_US = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n_pin,
  input wire logic sck_pin,
  input wire logic si_pin,
  input wire logic so,
  input wire logic so_oe
);
  logic       sck_r, sck_nxt;
  logic [5:0] rises_r, rises_nxt;
  logic [7:0] op_r, op_nxt;
  // sck rises in this frame, and the opcode they carried
  always_comb begin
    sck_nxt   = sck_pin;
    rises_nxt = rises_r;
    op_nxt    = op_r;
    if (cs_n_pin) begin
      rises_nxt = 6'h00;
    end else if (sck_pin && !sck_r && rises_r != 6'h3F) begin
      rises_nxt = rises_r + 6'h01;
      if (rises_r < 6'h08) begin
        op_nxt = {op_r[6:0], si_pin};
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_r   <= 1'b0;
      rises_r <= 6'h00;
      op_r    <= 8'h00;
    end else begin
      sck_r   <= sck_nxt;
      rises_r <= rises_nxt;
      op_r    <= op_nxt;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_release;
    $rose(cs_n_pin);
  endsequence
  sequence s_oe_start;
    $rose(so_oe);
  endsequence
  property p_oe_stands;
    so_oe && !cs_n_pin && !$past(cs_n_pin, 6) |=> so_oe;
  endproperty
  AST_OE_RISE_FRAME: assert property (s_oe_start |-> !cs_n_pin &&
    ((op_r == OP_STATUS && rises_r == 6'h08) || (op_r == OP_READ && rises_r == 6'h30)))
    else $error("output enabled outside a read or status frame");
  AST_OE_QUIET_OPCODE: assert property (rises_r != 6'h00 && rises_r < 6'h08 |-> !so_oe)
    else $error("output enabled during opcode");
  AST_OE_QUIET_PROG: assert property (op_r == OP_PROG && rises_r >= 6'h08 |-> !so_oe)
    else $error("output enabled in program frame");
  AST_OE_QUIET_DUMMY: assert property (op_r == OP_READ && rises_r >= 6'h08 && rises_r < 6'h30
    |-> !so_oe) else $error("output enabled before dummy bytes end");
  AST_OE_DROP: assert property (s_release |-> ##[1:6] !so_oe)
    else $error("output still enabled after release");
  AST_OE_IDLE: assert property (cs_n_pin [*6] |-> !so_oe)
    else $error("output enabled while deselected");
  AST_OE_HOLD: assert property (p_oe_stands)
    else $error("output enable dropped inside frame");
  AST_SO_ON_FALL: assert property (so_oe && $past(so_oe) && $changed(so)
    |-> !sck_pin && !$past(sck_pin, 2)) else $error("output changed outside sck low phase");
endmodule // otpsr_asserts

bind otpsr_top otpsr_asserts #(
  .SECURITY_PROGRAM_TIME_US(SECURITY_PROGRAM_TIME_US)
) chk_u (.clk(clk), .rst_n(rst_n), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin),
  .si_pin(si_pin), .so(so), .so_oe(so_oe));
`default_nettype wire

// ### verif/otpsr_host_model.sv
/*
  Behavioural SPI host, mode 0, MSB first.
  Assumes clk is the core clock; half_clk sets the SCK half period; an
  undriven SO line reads as the inverse of its last driven bit.
*/
`timescale 1ns/10ps
`default_nettype none
module otpsr_host_model (
  input  wire logic clk,
  input  wire logic so,
  input  wire logic so_oe,
  output logic      cs_n_pin,
  output logic      sck_pin,
  output logic      si_pin
);
  int half_clk = 5;
  initial begin
    cs_n_pin = 1'b1;
    sck_pin  = 1'b0;
    si_pin   = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic sel();
    tick(3);
    cs_n_pin = 1'b0;
  endtask
  // released data line shows the inverse of its last value
  task automatic desel();
    tick(half_clk);
    cs_n_pin = 1'b1;
    si_pin   = ~si_pin;
    tick(6);
  endtask
  task automatic xbit(input logic b, output logic r);
    si_pin = b;
    tick(half_clk);
    sck_pin = 1'b1;
    r = so_oe ? so : ~so;
    tick(half_clk);
    sck_pin = 1'b0;
  endtask
  task automatic xbyte(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], q[i]);
    end
  endtask
endmodule // otpsr_host_model
`default_nettype wire

// ### verif/otpsr_bench.sv
/*
  Self-checking bench for otpsr_top with the SPI host model.
  Assumes a programming pass of 250 clk (parameter set to 2).
*/
`timescale 1ns/10ps
`default_nettype none
module otpsr_bench;
  import otpsr_pkg::*;
  logic       clk;
  logic       rst_n;
  logic       cs_n_pin;
  logic       sck_pin;
  logic       si_pin;
  logic       so;
  logic       so_oe;
  logic       b;
  logic [7:0] s;
  logic [7:0] q;
  logic [7:0] fac;
  logic [7:0] rd [128];
  int         fail_count;
  int         checked;

  always #4 clk = ~clk;
  otpsr_top #(.SECURITY_PROGRAM_TIME_US(2)) dut_u (.clk(clk), .rst_n(rst_n),
    .cs_n_pin(cs_n_pin), .sck_pin(sck_pin), .si_pin(si_pin), .so(so), .so_oe(so_oe));
  otpsr_host_model host_u (.clk(clk), .so(so), .so_oe(so_oe), .cs_n_pin(cs_n_pin),
    .sck_pin(sck_pin), .si_pin(si_pin));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
  endtask
  task automatic hdr(input logic [7:0] op, input logic [23:0] a);
    host_u.sel();
    host_u.xbyte(op, q);
    host_u.xbyte(a[23:16], q);
    host_u.xbyte(a[15:8], q);
    host_u.xbyte(a[7:0], q);
  endtask
  task automatic cmd(input logic [7:0] op);
    host_u.sel();
    host_u.xbyte(op, q);
    host_u.desel();
  endtask
  task automatic status(output logic [7:0] st);
    host_u.sel();
    host_u.xbyte(OP_STATUS, q);
    host_u.xbyte(ZERO_BYTE, st);
    host_u.desel();
  endtask
  task automatic prog(input logic [23:0] a, input int n);
    hdr(OP_PROG, a);
    for (int i = 0; i < n; i++) begin
      host_u.xbyte(8'hA5 ^ i[7:0], q);
    end
    host_u.desel();
  endtask
  task automatic rdx(input logic [23:0] a, input int n);
    hdr(OP_READ, a);
    host_u.xbyte(ZERO_BYTE, q);
    host_u.xbyte(ZERO_BYTE, q);
    for (int i = 0; i < n; i++) begin
      host_u.xbyte(ZERO_BYTE, rd[i]);
    end
    host_u.desel();
  endtask
  // first status byte returned, then stay selected until ready
  task automatic poll(output logic [7:0] first);
    logic [7:0] st;
    host_u.sel();
    host_u.xbyte(OP_STATUS, q);
    host_u.xbyte(ZERO_BYTE, first);
    st = first;
    for (int k = 0; k < 40 && st[STAT_BUSY_BIT]; k++) begin
      host_u.xbyte(ZERO_BYTE, q);
      host_u.xbyte(ZERO_BYTE, st);
    end
    host_u.desel();
    chk(st, ZERO_BYTE);
  endtask

  task automatic t_idle();
    status(s);
    chk(s, 8'h00);
    chk({7'h00, so_oe}, 8'h00);
    cmd(OP_WREN);
    status(s);
    chk(s, 8'h02);
    cmd(OP_WRDI);
    status(s);
    chk(s, 8'h00);
  endtask
  task automatic t_refuse();
    prog(24'h000000, 1);
    status(s);
    chk(s, 8'h00);
    rdx(24'h000000, 1);
    chk(rd[0], ERASED);
  endtask
  task automatic t_abort();
    int cut [3] = '{16, 24, 36};
    for (int j = 0; j < 3; j++) begin
      cmd(OP_WREN);
      host_u.sel();
      host_u.xbyte(OP_PROG, q);
      // bits after opcode: short address, no data byte, one and a half data bytes
      repeat (cut[j]) host_u.xbit(1'b0, b);
      host_u.desel();
      status(s);
      chk(s, 8'h00);
    end
    rdx(24'h000000, 1);
    chk(rd[0], ERASED);
  endtask
  task automatic t_wrap();
    rdx(24'h00007F, 1);
    fac = rd[0];
    cmd(OP_WREN);
    prog(24'hFFFF7E, 3);
    poll(s);
    chk(s, 8'h01);
    rdx(24'h00003E, 2);
    chk(rd[0], 8'hA5);
    chk(rd[1], 8'hA4);
    host_u.half_clk = 8;
    rdx(24'h00007F, 3);
    host_u.half_clk = 5;
    chk(rd[1], 8'hA7);
    chk(rd[2], ERASED);
    chk(rd[0], fac);
    cmd(OP_WREN);
    prog(24'h000000, 1);
    status(s);
    chk(s, 8'h00);
    rdx(24'h000000, 1);
    chk(rd[0], 8'hA7);
    hdr(OP_READ, 24'h000000);
    host_u.xbyte(ZERO_BYTE, q);
    host_u.xbyte(ZERO_BYTE, q);
    repeat (3) host_u.xbit(1'b0, b);
    host_u.desel();
    chk({7'h00, so_oe}, 8'h00);
  endtask
  task automatic t_long();
    int i;
    do_reset();
    cmd(OP_WREN);
    prog(24'h000005, 66);
    poll(s);
    chk(s, 8'h01);
    rdx(24'h000000, 64);
    for (int a = 0; a < 64; a++) begin
      i = (a + 59) % 64;
      if (i < 2) begin
        i += 64;
      end
      chk(rd[a], 8'hA5 ^ i[7:0]);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    fail_count = 0;
    checked = 0;
    do_reset();
    t_idle();
    t_refuse();
    t_abort();
    t_wrap();
    t_long();
    results();
  end
  initial begin
    repeat (80000) @(posedge clk);
    fail_count++;
    results();
  end
endmodule // otpsr_bench
`default_nettype wire
